/* prgs_pkg.sv */
package prgs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned POR_MIN_US       = 1000;
  localparam int unsigned RST_MAX_US       = 10000;
  localparam int unsigned POR_MIN_CYC      =
    (POR_MIN_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Divide before the last scaling; the full product overflows 32 bits
  localparam int unsigned RST_MAX_CYC      =
    (RST_MAX_US * 1000) / CLK_PERIOD_PS * 1000;
  localparam int unsigned BUS_RELEASE_CYC  = 2;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned BUS_W   = 8;
  localparam int unsigned STRAP_W = 8;
  localparam int unsigned CNT_W   = 24;
  localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    PRGS_OFF  = 4'b0001,
    PRGS_RST  = 4'b0010,
    PRGS_RUN  = 4'b0100,
    PRGS_HIZ  = 4'b1000
  } prgs_state_e;

  typedef struct packed {
    logic             reset_active;
    logic             over_long;
    logic             short_por;
    logic             strap_valid;
  } prgs_status_s;

endpackage : prgs_pkg

/* prgs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module prgs_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Level in and out
  input  wire logic d,
  output var  logic q
);
  logic meta_q;

  // Two stages; first one is read by the second only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : prgs_sync
`default_nettype wire

/* prgs_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module prgs_seq
  import prgs_pkg::*;
#(
  parameter int unsigned POR_CYC = prgs_pkg::POR_MIN_CYC,
  parameter int unsigned MAX_CYC = prgs_pkg::RST_MAX_CYC
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // Board pins
  input  wire logic                        power_ok_in,
  input  wire logic                        bus_reset_in_n,
  input  wire logic                        mgmt_interrupt_in_n,
  input  wire logic [prgs_pkg::STRAP_W-1:0] strap_in,
  // Core side
  input  wire logic                        core_fault,
  input  wire logic [prgs_pkg::BUS_W-1:0]  core_bus_out,
  input  wire logic                        core_bus_oe,
  // Bus pins
  output logic [prgs_pkg::BUS_W-1:0]       system_bus_out,
  output logic                             system_bus_oe,
  output logic                             internal_fault_out_n,
  // Core control and status
  output logic                             core_reset,
  output logic                             cache_invalidate,
  output logic [prgs_pkg::STRAP_W-1:0]     strap_cfg,
  output logic                             outputs_hiz,
  output prgs_pkg::prgs_status_s           status
);
  import prgs_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic pok_s;
  logic rst_n_s;
  logic smi_s;
  logic [STRAP_W-1:0] strap_s;

  prgs_sync u_pok (.mclk(mclk), .arst_n(arst_n), .d(power_ok_in),
                   .q(pok_s));
  prgs_sync u_rst (.mclk(mclk), .arst_n(arst_n), .d(bus_reset_in_n),
                   .q(rst_n_s));
  // Fed inverted so the cleared flops read as an idle pin
  prgs_sync u_smi (.mclk(mclk), .arst_n(arst_n),
                   .d(!mgmt_interrupt_in_n), .q(smi_s));

  // One synchroniser per strap bit
  genvar gi;
  generate
    for (gi = 0; gi < STRAP_W; gi++) begin : g_strap
      prgs_sync u_s (.mclk(mclk), .arst_n(arst_n), .d(strap_in[gi]),
                     .q(strap_s[gi]));
    end
  endgenerate

  // ****************************************************************
  // Reset qualification
  // ****************************************************************
  prgs_state_e st_q, st_d;
  logic        rst_prev_q;
  logic [CNT_W-1:0] por_cnt_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic        rel_q;
  logic        fault_q;
  logic        over_q;
  logic        short_q;
  logic        sv_q;
  logic [STRAP_W-1:0] strap_q;

  // Power-good low overrides the reset pin entirely
  wire rst_int  = !pok_s || !rst_n_s;
  wire rst_fall = rst_prev_q && !rst_int;
  wire smi_rel  = rst_fall && smi_s;
  wire por_max  = por_cnt_q == CNT_W'(POR_CYC);
  wire hold_max = hold_cnt_q == CNT_W'(MAX_CYC);

  // State selection
  always_comb begin
    st_d = st_q;
    case (st_q)
      PRGS_OFF: if (pok_s) st_d = PRGS_RST;
      PRGS_RST: if (!pok_s) st_d = PRGS_OFF;
                else if (!rst_int) st_d = smi_rel ? PRGS_HIZ : PRGS_RUN;
      PRGS_RUN: if (!pok_s) st_d = PRGS_OFF;
                else if (rst_int) st_d = PRGS_RST;
      PRGS_HIZ: if (!pok_s) st_d = PRGS_OFF;
                else if (rst_int) st_d = PRGS_RST;
      default:  st_d = PRGS_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= PRGS_OFF;
      rst_prev_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      rst_prev_q <= rst_int;
    end
  end

  // Counts power-on hold time since power-good rose
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) por_cnt_q <= '0;
    else if (!pok_s) por_cnt_q <= '0;
    else if (rst_int && !por_max) por_cnt_q <= por_cnt_q + 1'b1;
  end

  // Counts continuous reset while power-good high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) hold_cnt_q <= '0;
    else if (!pok_s || !rst_int) hold_cnt_q <= '0;
    else if (!hold_max) hold_cnt_q <= hold_cnt_q + 1'b1;
  end

  // Status flags; cleared only while power-good is low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      over_q  <= 1'b0;
      short_q <= 1'b0;
    end else begin
      if (hold_max) over_q <= 1'b1;
      else if (!pok_s) over_q <= 1'b0;
      if (rst_fall && !por_max) short_q <= 1'b1;
      else if (!pok_s) short_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Straps and fault
  // ****************************************************************
  // Straps caught only at the release edge, never at async reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_q <= STRAP_RST;
      sv_q    <= 1'b0;
    end else if (!pok_s) begin
      sv_q    <= 1'b0;
    end else if (rst_fall) begin
      strap_q <= strap_s;
      sv_q    <= 1'b1;
    end
  end

  // Fault is sticky; only reset clears it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) fault_q <= 1'b0;
    else if (rst_int) fault_q <= 1'b0;
    else if (core_fault) fault_q <= 1'b1;
  end

  // ****************************************************************
  // Bus release
  // ****************************************************************
  // One clean clock out of reset before the bus may be driven
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rel_q <= 1'b0;
    else rel_q <= !rst_int;
  end

  wire drive_ok = (st_q == PRGS_RUN) && !rst_int;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      system_bus_out <= '0;
      system_bus_oe  <= 1'b0;
    end else begin
      system_bus_out <= drive_ok ? core_bus_out : '0;
      system_bus_oe  <= drive_ok && core_bus_oe && rel_q;
    end
  end

  // Defined state and cache discard while reset active
  assign core_reset           = rst_int || st_q == PRGS_OFF;
  assign cache_invalidate     = core_reset;
  assign internal_fault_out_n = !fault_q;
  assign outputs_hiz          = st_q == PRGS_HIZ;
  assign strap_cfg            = strap_q;
  assign status.reset_active  = core_reset;
  assign status.over_long     = over_q;
  assign status.short_por     = short_q;
  assign status.strap_valid   = sv_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  bus_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rst_int |-> ##1 !system_bus_oe[*2])
    else $error("bus driven during reset");
  fault_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !internal_fault_out_n && !rst_int |=> !internal_fault_out_n)
    else $error("fault dropped without reset");
  strap_take_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rst_fall && pok_s |=> strap_cfg == $past(strap_s))
    else $error("strap not captured");
  pok_reset_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !pok_s |-> core_reset && cache_invalidate)
    else $error("no reset while power low");
  hiz_entry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    smi_rel && pok_s |=> outputs_hiz ##1 !system_bus_oe)
    else $error("no tristate on mgmt release");
  over_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
    hold_max |=> status.over_long)
    else $error("long reset not flagged");
  short_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rst_fall && pok_s && !por_max |=> status.short_por)
    else $error("short power-on reset not flagged");
  run_norst_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !pok_s |=> st_q == PRGS_OFF && !system_bus_oe)
    else $error("running without power good");

  run_c: cover property (@(posedge mclk) st_q == PRGS_RUN);
  hiz_c: cover property (@(posedge mclk) st_q == PRGS_HIZ);
  fault_c: cover property (@(posedge mclk) !internal_fault_out_n);
  over_c: cover property (@(posedge mclk) status.over_long);
endmodule : prgs_seq
`default_nettype wire

/* prgs_board.sv */
`timescale 1ns/1ps
`default_nettype none
module prgs_board
  import prgs_pkg::*;
#(
  parameter int unsigned POR_CYC = 20
) (
  // Clock and commands from the bench
  input  wire logic                        mclk,
  input  wire logic                        supply_ok,
  input  wire logic                        rst_req,
  input  wire logic [prgs_pkg::STRAP_W-1:0] strap_val,
  // Board pins
  output logic                             power_ok_in,
  output logic                             bus_reset_in_n,
  output logic [prgs_pkg::STRAP_W-1:0]     strap_in
);
  int unsigned hold_q = 0;

  initial begin
    power_ok_in    = 1'b0;
    bus_reset_in_n = 1'b0;
    strap_in       = 8'h00;
  end

  // Registered levels: one clean edge per change, never a bounce
  always @(negedge mclk) begin
    power_ok_in <= supply_ok;
    strap_in    <= strap_val;
    if (!power_ok_in || rst_req) begin
      hold_q         <= 0;
      bus_reset_in_n <= 1'b0;
    end else if (hold_q < POR_CYC) begin
      hold_q <= hold_q + 1;
    end else begin
      bus_reset_in_n <= 1'b1;
    end
  end
endmodule : prgs_board
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import prgs_pkg::*;
  localparam int unsigned POR = 20;
  logic mclk = 1'b0, arst_n = 1'b0, supply_ok = 1'b0, rst_req = 1'b1;
  logic mgmt_n = 1'b1, core_fault = 1'b0, core_oe = 1'b0;
  logic [STRAP_W-1:0] strap_val = 8'h00, strap_in, strap_cfg;
  logic [BUS_W-1:0] core_dat = 8'h00, sys_out;
  logic power_ok_in, bus_reset_in_n, sys_oe, fault_n, core_reset;
  logic cache_inv, hiz;
  prgs_status_s status;
  int mismatches = 0;
  int n_tests = 0;
  logic [7:0] strap_q[$];
  logic [7:0] exp_dat;

  // ****************************************************************
  // Clock, partner and design
  // ****************************************************************
  always #2 mclk = ~mclk;

  prgs_board #(.POR_CYC(POR)) u_board (.mclk(mclk),
    .supply_ok(supply_ok), .rst_req(rst_req), .strap_val(strap_val),
    .power_ok_in(power_ok_in), .bus_reset_in_n(bus_reset_in_n),
    .strap_in(strap_in));

  prgs_seq #(.POR_CYC(POR), .MAX_CYC(100)) u_dut (.mclk(mclk),
    .arst_n(arst_n), .power_ok_in(power_ok_in),
    .bus_reset_in_n(bus_reset_in_n), .mgmt_interrupt_in_n(mgmt_n),
    .strap_in(strap_in), .core_fault(core_fault),
    .core_bus_out(core_dat), .core_bus_oe(core_oe),
    .system_bus_out(sys_out), .system_bus_oe(sys_oe),
    .internal_fault_out_n(fault_n), .core_reset(core_reset),
    .cache_invalidate(cache_inv), .strap_cfg(strap_cfg),
    .outputs_hiz(hiz), .status(status));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Bounded wait, since a stuck reset would otherwise hang the run
  task automatic wait_rst(input logic v);
    int i;
    for (i = 0; i < 200 && core_reset !== v; i++) begin
      @(negedge mclk);
    end
    if (i == 200) begin
      mismatches++;
      end_of_test();
    end
  endtask : wait_rst

  task automatic end_of_test;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h083a_af5b));
    cyc(10);
    arst_n <= 1'b1;
    cyc(4);
    chk(8'(core_reset), 8'h01);
    for (int k = 0; k < 3; k++) begin
      strap_val <= 8'($urandom);
      cyc(1);
      strap_q.push_back(strap_val);
      mgmt_n    <= (k == 2) ? 1'b0 : 1'b1;
      supply_ok <= 1'b1;
      rst_req   <= 1'b0;
      cyc(POR / 2);
      chk(8'(cache_inv), 8'h01);
      wait_rst(1'b0);
      cyc(2);
      chk(strap_cfg, strap_q.pop_front());
      chk(8'(cache_inv), 8'h00);
      chk(8'(hiz), (k == 2) ? 8'h01 : 8'h00);
      chk(8'(status), 8'h01);
      mgmt_n   <= 1'b1;
      core_oe  <= 1'b1;
      core_dat <= 8'($urandom);
      cyc(4);
      exp_dat = (k == 2) ? 8'h00 : core_dat;
      chk(8'(sys_oe), (k == 2) ? 8'h00 : 8'h01);
      chk(sys_out, exp_dat);
      core_fault <= 1'b1;
      cyc(1);
      core_fault <= 1'b0;
      cyc(8);
      chk(8'(fault_n), 8'h00);
      if (k == 1) begin
        // Supply collapse in mid-run forces the core back into reset
        supply_ok <= 1'b0;
        cyc(5);
        chk(8'(core_reset), 8'h01);
        chk(8'(sys_oe), 8'h00);
        chk(8'(status), 8'h08);
      end else begin
        rst_req <= 1'b1;
        cyc(6);
        chk(8'(sys_oe), 8'h00);
        chk(8'(fault_n), 8'h01);
        chk(8'(status), 8'h09);
      end
      core_oe <= 1'b0;
    end
    // Reset left on past the limit must be flagged, power still good
    cyc(110);
    chk(8'(status), 8'h0d);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
